// ---- rtl/uedc_params.svh ----
/*
  Constants of the endpoint DMA command unit: command codes, register field
  positions, reset values and buffer framing.
  Assumes it is included by bare name from the package and the design file.
*/
`ifndef UEDC_PARAMS_SVH
`define UEDC_PARAMS_SVH
`define UEDC_CMD_CFG_WR 8'hF0
`define UEDC_CMD_CFG_RD 8'hF1
`define UEDC_CMD_CNT_WR 8'hF2
`define UEDC_CMD_CNT_RD 8'hF3
`define UEDC_CMD_RESET 8'hF6
`define UEDC_CMD_BUFR_GAP 8'h11
`define UEDC_NIB_BUFW 4'h0
`define UEDC_NIB_BUFR 4'h1
`define UEDC_NIB_STAT 4'h5
`define UEDC_CFG_EOT_EN_BIT 15
`define UEDC_CFG_RUN_BIT 3
`define UEDC_CFG_EP_MSB 7
`define UEDC_CFG_EP_LSB 4
`define UEDC_CFG_WMASK 16'hC0FB
`define UEDC_CFG_RESET 16'h0000
`define UEDC_CNT_RESET 16'h0000
`define UEDC_LEN_BYTES 2
`endif

// ---- rtl/uedc_pkg.sv ----
/*
  Types of the endpoint DMA command unit.
  Assumes the constants header sits beside it.
*/
`include "uedc_params.svh"
package uedc_pkg;
  // One host port request, sampled on core_clk.
  typedef struct packed {
    logic sel;
    logic wr;
    logic rd;
    logic [15:0] wdata;
  } uedc_host_req_t;

  // One byte travelling through the DMA FIFO.
  typedef struct packed {
    logic last;
    logic [7:0] data;
  } uedc_beat_t;

  // Command being served by the data phases.
  typedef enum logic [2:0] {
    CM_NONE, CM_BUFW, CM_BUFR, CM_STAT, CM_CFG, CM_CNT
  } uedc_cmd_t;

  // Memory side of the DMA engine.
  typedef enum logic {DM_MOVE, DM_SEAL} uedc_dma_state_t;
endpackage

// ---- rtl/uedc_core.sv ----
/*
  Endpoint buffer command decoder with DMA engine and its byte FIFO.
  Assumes the host port strobes are one-cycle pulses on core_clk, the USB
  engine supplies status, direction and buffer-full levels, and the external
  end-of-transfer line is asynchronous.
*/
`timescale 1ns/1ps
`include "uedc_params.svh"
module uedc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  input wire logic flush,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;

  // Pointers carry one extra bit so full and empty can be told apart.
  assign in_ready = (wp_r[AW-1:0] != rp_r[AW-1:0]) || (wp_r[AW] == rp_r[AW]);
  assign out_valid = wp_r != rp_r;
  assign out_data = mem[rp_r[AW-1:0]];

  // Write pointer and storage.
  always_ff @(posedge core_clk) begin
    if (srst || flush) begin
      wp_r <= '0;
    end else if (in_valid && in_ready) begin
      mem[wp_r[AW-1:0]] <= in_data;
      wp_r <= wp_r + 1'b1;
    end
  end

  // Read pointer.
  always_ff @(posedge core_clk) begin
    if (srst || flush) begin
      rp_r <= '0;
    end else if (out_valid && out_ready) begin
      rp_r <= rp_r + 1'b1;
    end
  end
endmodule

module uedc_core #(
  parameter int EP_BYTES = 64,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Host parallel port.
  input wire uedc_pkg::uedc_host_req_t host_req,
  input wire logic bus16,
  output logic [15:0] host_rdata_r,
  output logic host_rvalid_r,
  // USB engine side.
  input wire logic usb_bus_reset,
  input wire logic [15:0][7:0] ep_status,
  input wire logic [15:0] ep_is_in,
  input wire logic [15:0] ep_double,
  input wire logic [15:0] ep_buf_full,
  output logic ep_irq_clr_r,
  output logic [3:0] ep_irq_idx_r,
  output logic buf_commit_r,
  output logic buf_release_r,
  output logic [3:0] buf_ep_r,
  // DMA stream side.
  input wire logic dma_in_valid,
  output logic dma_in_ready,
  input wire logic [7:0] dma_in_data,
  output logic dma_out_valid,
  input wire logic dma_out_ready,
  output logic [7:0] dma_out_data,
  output logic dma_out_last,
  input wire logic end_of_transfer_signal,
  output logic dma_eot_r
);
  localparam int AW = $clog2(EP_BYTES);
  localparam logic [AW-1:0] HALF = AW'(EP_BYTES / 2);
  localparam logic [AW-1:0] FIRST = AW'(`UEDC_LEN_BYTES);

  logic [7:0] mem [16][EP_BYTES];
  logic rst;
  logic soft_rst_r;
  uedc_pkg::uedc_cmd_t cmd_r;
  logic [3:0] hep_r;
  logic [AW-1:0] hptr_r;
  logic phase_r;
  logic [15:0] cfg_r;
  logic [15:0] cnt_r;
  logic [15:0] wcnt_r;
  uedc_pkg::uedc_dma_state_t dst_r;
  logic half_r;
  logic [AW-1:0] rel_r;
  logic eot_pend_r;
  logic eot_s1_r, eot_s2_r, eot_s3_r;
  logic [7:0] c;
  logic cmd_stb, dat_wr, dat_rd;
  logic [3:0] dep;
  logic dir_in, run, eot_en, zero_stop;
  logic [AW-1:0] base, lim, abs_ptr;
  logic [15:0] plen;
  logic push_rd, pop_wr, last_rd, seal_go, ext_eot, cnt_hit;
  logic cfg_wr_lo, reload, fifo_flush;
  logic [15:0] reg_wval;
  uedc_pkg::uedc_beat_t fin, fout;
  logic fin_valid, fin_ready, fout_valid, fout_ready;

  // Endpoint index carried in the low nibble of a code.
  function automatic logic [3:0] f_ep(input logic [7:0] code);
    return code[3:0];
  endfunction

  // Pointer plus a small step, wrapping inside one endpoint buffer.
  function automatic logic [AW-1:0] f_step(input logic [AW-1:0] p, input logic two);
    return p + (two ? AW'(2) : AW'(1));
  endfunction

  // The reset command acts exactly like the reset input.
  assign rst = srst || soft_rst_r;
  assign c = host_req.wdata[7:0];
  assign cmd_stb = host_req.wr && host_req.sel;
  assign dat_wr = host_req.wr && !host_req.sel;
  assign dat_rd = host_req.rd && !host_req.sel;

  // Reset command pulse; it lasts one cycle and is itself part of the reset it causes.
  always_ff @(posedge core_clk) begin
    if (srst || soft_rst_r) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= cmd_stb && (c == `UEDC_CMD_RESET);
    end
  end

  // Command decode: buffer, status and register commands select the data phase.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmd_r <= uedc_pkg::CM_NONE;
      hep_r <= 4'h0;
    end else if (cmd_stb) begin
      hep_r <= f_ep(c);
      if (c[7:4] == `UEDC_NIB_BUFW && c[3:0] != 4'h0) begin
        cmd_r <= uedc_pkg::CM_BUFW;
      end else if (c[7:4] == `UEDC_NIB_BUFR && c != `UEDC_CMD_BUFR_GAP) begin
        cmd_r <= uedc_pkg::CM_BUFR;
      end else if (c[7:4] == `UEDC_NIB_STAT) begin
        cmd_r <= uedc_pkg::CM_STAT;
      end else if (c == `UEDC_CMD_CFG_WR || c == `UEDC_CMD_CFG_RD) begin
        cmd_r <= uedc_pkg::CM_CFG;
      end else if (c == `UEDC_CMD_CNT_WR || c == `UEDC_CMD_CNT_RD) begin
        cmd_r <= uedc_pkg::CM_CNT;
      end else begin
        cmd_r <= uedc_pkg::CM_NONE;
      end
    end
  end

  // Host buffer pointer and two-byte register phase.
  always_ff @(posedge core_clk) begin
    if (rst || cmd_stb) begin
      hptr_r <= '0;
      phase_r <= 1'b0;
    end else if (dat_wr || dat_rd) begin
      hptr_r <= f_step(hptr_r, bus16);
      phase_r <= !phase_r;
    end
  end

  // Value written into a two-byte register; bytes arrive low first.
  always_comb begin
    if (bus16) begin
      reg_wval = host_req.wdata;
    end else if (!phase_r) begin
      reg_wval = {8'h00, host_req.wdata[7:0]};
    end else begin
      reg_wval = {host_req.wdata[7:0], 8'h00};
    end
  end

  // Only the lanes being written are touched.
  assign cfg_wr_lo = dat_wr && cmd_r == uedc_pkg::CM_CFG && (bus16 || !phase_r);
  assign reload = cfg_wr_lo && reg_wval[`UEDC_CFG_RUN_BIT];

  // Transfer count register; a bus reset does not reach it.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_r <= `UEDC_CNT_RESET;
    end else if (dat_wr && cmd_r == uedc_pkg::CM_CNT) begin
      if (bus16 || !phase_r) begin
        cnt_r[7:0] <= reg_wval[7:0];
      end
      if (bus16 || phase_r) begin
        cnt_r[15:8] <= reg_wval[15:8];
      end
    end
  end

  // DMA configuration; the run bit also drops on bus reset and on end of transfer.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_r <= `UEDC_CFG_RESET;
    end else begin
      if (dat_wr && cmd_r == uedc_pkg::CM_CFG) begin
        if (bus16 || !phase_r) begin
          cfg_r[7:0] <= reg_wval[7:0] & 8'(`UEDC_CFG_WMASK);
        end
        if (bus16 || phase_r) begin
          cfg_r[15:8] <= reg_wval[15:8] & 8'hC0;
        end
      end else if (usb_bus_reset || cnt_hit || ext_eot) begin
        cfg_r[`UEDC_CFG_RUN_BIT] <= 1'b0;
      end
    end
  end

  assign dep = cfg_r[`UEDC_CFG_EP_MSB:`UEDC_CFG_EP_LSB];
  assign run = cfg_r[`UEDC_CFG_RUN_BIT];
  assign eot_en = cfg_r[`UEDC_CFG_EOT_EN_BIT];
  assign dir_in = ep_is_in[dep];
  assign zero_stop = eot_en && (wcnt_r == 16'h0000);

  // Working counter: reload on enable, one down per byte at the DMA port.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wcnt_r <= `UEDC_CNT_RESET;
    end else if (reload) begin
      wcnt_r <= cnt_r;
    end else if ((dma_in_valid && dma_in_ready) || (dma_out_valid && dma_out_ready)) begin
      wcnt_r <= wcnt_r - 16'h0001;
    end
  end

  // Count reaching zero ends the transfer when enabled.
  assign cnt_hit = run && eot_en && wcnt_r == 16'h0001 &&
                   ((dma_in_valid && dma_in_ready) || (dma_out_valid && dma_out_ready));

  // Host read data and endpoint interrupt clear.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      host_rdata_r <= 16'h0000;
      host_rvalid_r <= 1'b0;
      ep_irq_clr_r <= 1'b0;
      ep_irq_idx_r <= 4'h0;
    end else begin
      host_rvalid_r <= dat_rd;
      ep_irq_clr_r <= cmd_stb && c[7:4] == `UEDC_NIB_STAT;
      if (cmd_stb) begin
        ep_irq_idx_r <= f_ep(c);
      end
      if (dat_rd) begin
        unique case (cmd_r)
          uedc_pkg::CM_BUFR, uedc_pkg::CM_BUFW: begin
            host_rdata_r <= {bus16 ? mem[hep_r][f_step(hptr_r, 1'b0)] : 8'h00,
                             mem[hep_r][hptr_r]};
          end
          uedc_pkg::CM_STAT: host_rdata_r <= {8'h00, ep_status[hep_r]};
          uedc_pkg::CM_CFG: begin
            host_rdata_r <= bus16 ? cfg_r : {8'h00, phase_r ? cfg_r[15:8] : cfg_r[7:0]};
          end
          uedc_pkg::CM_CNT: begin
            host_rdata_r <= bus16 ? wcnt_r : {8'h00, phase_r ? wcnt_r[15:8] : wcnt_r[7:0]};
          end
          uedc_pkg::CM_NONE: host_rdata_r <= 16'h0000;
        endcase
      end
    end
  end

  // External end of transfer passes two flip-flops before use.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      eot_s1_r <= 1'b0;
      eot_s2_r <= 1'b0;
      eot_s3_r <= 1'b0;
    end else begin
      eot_s1_r <= end_of_transfer_signal;
      eot_s2_r <= eot_s1_r;
      eot_s3_r <= eot_s2_r;
    end
  end
  assign ext_eot = run && eot_s2_r && !eot_s3_r;

  // Buffer geometry: a double-buffered endpoint splits into two halves.
  assign base = half_r ? HALF : '0;
  assign lim = ep_double[dep] ? HALF : AW'(EP_BYTES - 1);
  assign abs_ptr = base + rel_r;
  assign plen = {mem[dep][base + AW'(1)], mem[dep][base]};

  // Reading toward the DMA port stops after the byte named by the packet length.
  assign last_rd = {{(16 - AW){1'b0}}, rel_r} == plen + 16'h0001;
  // Full still shows for one cycle after a release, so that cycle pushes nothing.
  assign push_rd = run && !dir_in && ep_buf_full[dep] && fin_ready && !buf_release_r;
  assign pop_wr = dir_in && dst_r == uedc_pkg::DM_MOVE && fout_valid;
  assign seal_go = dst_r == uedc_pkg::DM_MOVE && dir_in &&
                   ((pop_wr && f_step(rel_r, 1'b0) == lim) || (eot_pend_r && !fout_valid));
  assign fifo_flush = reload;

  // FIFO source and sink follow the transfer direction.
  always_comb begin
    if (dir_in) begin
      fin.data = dma_in_data;
      fin.last = 1'b0;
      fin_valid = dma_in_valid && dma_in_ready;
      fout_ready = dst_r == uedc_pkg::DM_MOVE;
    end else begin
      fin.data = mem[dep][abs_ptr];
      fin.last = last_rd;
      fin_valid = push_rd;
      fout_ready = dma_out_ready && run && !zero_stop;
    end
  end

  // Back-pressure reaches the DMA source through the FIFO.
  assign dma_in_ready = fin_ready && run && dir_in && !zero_stop && !eot_pend_r;
  assign dma_out_valid = fout_valid && run && !dir_in && !zero_stop;
  assign dma_out_data = fout.data;
  assign dma_out_last = fout.last;

  uedc_fifo #(
    .WIDTH($bits(uedc_pkg::uedc_beat_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .srst(rst),
    .flush(fifo_flush),
    .in_valid(fin_valid),
    .in_ready(fin_ready),
    .in_data(fin),
    .out_valid(fout_valid),
    .out_ready(fout_ready),
    .out_data(fout)
  );

  // DMA walk over the endpoint buffer, skipping the length bytes.
  always_ff @(posedge core_clk) begin
    if (rst || reload) begin
      dst_r <= uedc_pkg::DM_MOVE;
      rel_r <= FIRST;
      half_r <= 1'b0;
    end else if (dst_r == uedc_pkg::DM_SEAL) begin
      dst_r <= uedc_pkg::DM_MOVE;
      rel_r <= FIRST;
      half_r <= ep_double[dep] ? !half_r : 1'b0;
    end else if (seal_go) begin
      dst_r <= uedc_pkg::DM_SEAL;
      if (pop_wr) begin
        rel_r <= f_step(rel_r, 1'b0);
      end
    end else if (pop_wr) begin
      rel_r <= f_step(rel_r, 1'b0);
    end else if (push_rd) begin
      if (last_rd || plen == 16'h0000) begin
        rel_r <= FIRST;
        half_r <= ep_double[dep] ? !half_r : 1'b0;
      end else begin
        rel_r <= f_step(rel_r, 1'b0);
      end
    end
  end

  // External end of transfer on an IN endpoint waits for the FIFO to drain, then sends the buffer.
  always_ff @(posedge core_clk) begin
    if (rst || reload) begin
      eot_pend_r <= 1'b0;
    end else if (ext_eot && dir_in) begin
      eot_pend_r <= 1'b1;
    end else if (dst_r == uedc_pkg::DM_SEAL) begin
      eot_pend_r <= 1'b0;
    end
  end

  // Buffer hand-over pulses and end-of-transfer pulse.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      buf_commit_r <= 1'b0;
      buf_release_r <= 1'b0;
      buf_ep_r <= 4'h0;
      dma_eot_r <= 1'b0;
    end else begin
      buf_commit_r <= dst_r == uedc_pkg::DM_SEAL;
      buf_release_r <= push_rd && (last_rd || plen == 16'h0000);
      buf_ep_r <= dep;
      dma_eot_r <= cnt_hit || ext_eot;
    end
  end

  // Buffer storage: host writes, DMA bytes and the sealed packet length.
  always_ff @(posedge core_clk) begin
    if (dat_wr && cmd_r == uedc_pkg::CM_BUFW) begin
      mem[hep_r][hptr_r] <= host_req.wdata[7:0];
      if (bus16) begin
        mem[hep_r][f_step(hptr_r, 1'b0)] <= host_req.wdata[15:8];
      end
    end
    if (pop_wr) begin
      mem[dep][abs_ptr] <= fout.data;
    end
    if (dst_r == uedc_pkg::DM_SEAL) begin
      mem[dep][base] <= 8'(rel_r - FIRST);
      mem[dep][base + AW'(1)] <= 8'h00;
    end
  end
endmodule

// ---- dv/uedc_properties.sv ----
/*
  Port checker of the endpoint DMA command unit, bound to uedc_core below.
  Assumes one core_clk domain with the synchronous active-high srst.
*/
`timescale 1ns/1ps
`include "uedc_params.svh"
module uedc_properties (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Host port and USB engine side.
  input wire uedc_pkg::uedc_host_req_t host_req,
  input wire logic host_rvalid_r,
  input wire logic usb_bus_reset,
  input wire logic ep_irq_clr_r,
  input wire logic [3:0] ep_irq_idx_r,
  input wire logic buf_commit_r,
  input wire logic buf_release_r,
  // DMA stream side.
  input wire logic dma_in_ready,
  input wire logic dma_out_valid,
  input wire logic dma_out_ready,
  input wire logic [7:0] dma_out_data,
  input wire logic dma_out_last,
  input wire logic dma_eot_r
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // Command strobes decoded once so the properties stay short.
  logic cmd_stat;
  logic cmd_rst;
  assign cmd_stat = host_req.sel && host_req.wr && host_req.wdata[7:4] == `UEDC_NIB_STAT;
  assign cmd_rst = host_req.sel && host_req.wr && host_req.wdata[7:0] == `UEDC_CMD_RESET;
  // Set by a packet release, cleared when a last byte leaves the FIFO in a cycle without a release.
  logic rel_seen_r;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rel_seen_r <= 1'b0;
    end else begin
      rel_seen_r <= buf_release_r ||
                    (rel_seen_r && !(dma_out_valid && dma_out_ready && dma_out_last));
    end
  end
  property p_rd_ans;
    host_req.rd |=> host_rvalid_r;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rv_cause;
    host_rvalid_r |-> $past(host_req.rd);
  endproperty
  a_rv_cause: assert property (p_rv_cause) else $error("answer without read");
  property p_stat_clr;
    cmd_stat |=> ep_irq_clr_r && ep_irq_idx_r == $past(host_req.wdata[3:0]);
  endproperty
  a_stat_clr: assert property (p_stat_clr) else $error("interrupt not cleared");
  property p_clr_cause;
    ep_irq_clr_r |-> $past(cmd_stat);
  endproperty
  a_clr_cause: assert property (p_clr_cause) else $error("stray interrupt clear");
  property p_eot_stop;
    dma_eot_r |-> !dma_in_ready ##1 !dma_in_ready;
  endproperty
  a_eot_stop: assert property (p_eot_stop) else $error("DMA runs after end");
  property p_commit_pulse;
    buf_commit_r |=> !buf_commit_r;
  endproperty
  a_commit_pulse: assert property (p_commit_pulse) else $error("commit held");
  property p_out_hold;
    dma_out_valid && !dma_out_ready |=>
      dma_out_valid && $stable(dma_out_data) && $stable(dma_out_last);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("offered byte dropped");
  property p_last_release;
    dma_out_valid && dma_out_ready && dma_out_last |-> rel_seen_r || buf_release_r;
  endproperty
  a_last_release: assert property (p_last_release) else $error("no release");
  property p_srst_quiet;
    $fell(srst) |-> !host_rvalid_r && !dma_in_ready && !dma_out_valid;
  endproperty
  a_srst_quiet: assert property (p_srst_quiet) else $error("busy after reset");
  property p_cmd_rst;
    cmd_rst |-> ##2 !dma_in_ready && !dma_out_valid && !dma_eot_r;
  endproperty
  a_cmd_rst: assert property (p_cmd_rst) else $error("reset command ignored");
  property p_bus_rst;
    usb_bus_reset && !host_req.wr |=> !dma_in_ready;
  endproperty
  a_bus_rst: assert property (p_bus_rst) else $error("run kept over bus reset");
  // Main scenarios that the bench must reach.
  c_eot: cover property (dma_eot_r);
  c_commit: cover property (buf_commit_r);
  c_release: cover property (buf_release_r);
  c_clr: cover property (ep_irq_clr_r);
endmodule

bind uedc_core uedc_properties chk (
  .core_clk(core_clk), .srst(srst), .host_req(host_req), .host_rvalid_r(host_rvalid_r),
  .usb_bus_reset(usb_bus_reset), .ep_irq_clr_r(ep_irq_clr_r), .ep_irq_idx_r(ep_irq_idx_r),
  .buf_commit_r(buf_commit_r), .buf_release_r(buf_release_r), .dma_in_ready(dma_in_ready),
  .dma_out_valid(dma_out_valid), .dma_out_ready(dma_out_ready),
  .dma_out_data(dma_out_data), .dma_out_last(dma_out_last), .dma_eot_r(dma_eot_r)
);

// ---- dv/uedc_dma_model.sv ----
/*
  Model of the external DMA controller on the stream side of the unit.
  Assumes the testbench fills txq, reads rxq and drives stall.
*/
`timescale 1ns/1ps
module uedc_dma_model (
  // Clock and flow control.
  input wire logic core_clk,
  input wire logic stall,
  // Bytes towards an IN endpoint.
  output logic dma_in_valid,
  input wire logic dma_in_ready,
  output logic [7:0] dma_in_data,
  // Bytes from an OUT endpoint.
  output logic dma_out_ready,
  input wire logic dma_out_valid,
  input wire logic [7:0] dma_out_data,
  input wire logic dma_out_last
);
  logic [7:0] txq[$];
  logic [8:0] rxq[$];
  // Idle values at time zero.
  initial begin
    dma_in_valid = 1'b0;
    dma_in_data = 8'h00;
    dma_out_ready = 1'b0;
  end
  // A byte stays offered until taken; idle data toggles so a stale byte never passes.
  always @(posedge core_clk) begin
    if (!dma_in_valid || dma_in_ready) begin
      if (txq.size() > 0) begin
        dma_in_valid <= 1'b1;
        dma_in_data <= txq.pop_front();
      end else begin
        dma_in_valid <= 1'b0;
        dma_in_data <= ~dma_in_data;
      end
    end
  end
  // Sink keeps every byte taken, stalling when told to.
  always @(posedge core_clk) begin
    if (dma_out_valid && dma_out_ready) begin
      rxq.push_back({dma_out_last, dma_out_data});
    end
    dma_out_ready <= !stall;
  end
endmodule

// ---- dv/tb_usb_endpoint_dma_command_unit.sv ----
/*
  Directed testbench of the endpoint DMA command unit on its host port, mostly 8-bit with two 16-bit buffer reads.
  Assumes the DMA model and the bound checker are compiled before it.
*/
`timescale 1ns/1ps
`include "uedc_params.svh"
module tb_usb_endpoint_dma_command_unit;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  uedc_pkg::uedc_host_req_t host_req = '0;
  logic usb_bus_reset = 1'b0;
  logic end_of_transfer_signal = 1'b0;
  logic stall = 1'b1;
  logic [15:0][7:0] ep_status;
  logic [15:0] ep_is_in = 16'h0008;
  logic [15:0] ep_buf_full = 16'h0000;
  logic bus16 = 1'b0;
  logic [15:0] ep_double = 16'h0004;
  logic [15:0] host_rdata_r;
  logic host_rvalid_r, ep_irq_clr_r, buf_commit_r, buf_release_r, dma_eot_r;
  logic [3:0] ep_irq_idx_r, buf_ep_r;
  logic dma_in_valid, dma_in_ready, dma_out_valid, dma_out_ready, dma_out_last;
  logic [7:0] dma_in_data, dma_out_data;
  logic [7:0] exp_w [4] = '{8'h02, 8'h00, 8'h5A, 8'hC3};
  int num_errors = 0;
  int num_checks = 0;

  // Clock of 4 ns.
  always #2 core_clk = ~core_clk;

  // Endpoint 2 is double buffered; the bus width changes only between accesses.
  uedc_core #(.EP_BYTES(64), .FIFO_DEPTH(8)) uut (
    .core_clk(core_clk), .srst(srst), .host_req(host_req), .bus16(bus16),
    .host_rdata_r(host_rdata_r), .host_rvalid_r(host_rvalid_r),
    .usb_bus_reset(usb_bus_reset), .ep_status(ep_status), .ep_is_in(ep_is_in),
    .ep_double(ep_double), .ep_buf_full(ep_buf_full), .ep_irq_clr_r(ep_irq_clr_r),
    .ep_irq_idx_r(ep_irq_idx_r), .buf_commit_r(buf_commit_r),
    .buf_release_r(buf_release_r), .buf_ep_r(buf_ep_r), .dma_in_valid(dma_in_valid),
    .dma_in_ready(dma_in_ready), .dma_in_data(dma_in_data), .dma_out_valid(dma_out_valid),
    .dma_out_ready(dma_out_ready), .dma_out_data(dma_out_data),
    .dma_out_last(dma_out_last), .end_of_transfer_signal(end_of_transfer_signal),
    .dma_eot_r(dma_eot_r)
  );

  uedc_dma_model dm (
    .core_clk(core_clk), .stall(stall), .dma_in_valid(dma_in_valid),
    .dma_in_ready(dma_in_ready), .dma_in_data(dma_in_data), .dma_out_ready(dma_out_ready),
    .dma_out_valid(dma_out_valid), .dma_out_data(dma_out_data), .dma_out_last(dma_out_last)
  );

  // The engine drops buffer full once the DMA has released the packet.
  always @(posedge core_clk) begin
    if (buf_release_r) begin
      ep_buf_full <= 16'h0000;
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One port access; upper lanes carry junk, and data is inverted once released.
  task automatic acc(input logic sel, input logic wr, input logic [7:0] d);
    @(posedge core_clk);
    host_req <= '{sel: sel, wr: wr, rd: !wr, wdata: {8'hEE, d}};
    @(posedge core_clk);
    host_req <= '{sel: 1'b0, wr: 1'b0, rd: 1'b0, wdata: ~{8'hEE, d}};
  endtask

  // The answer is looked at in the one cycle it stands.
  task automatic rd8(output logic [7:0] d);
    acc(1'b0, 1'b0, 8'h00);
    #1;
    d = host_rvalid_r === 1'b1 ? host_rdata_r[7:0] : 'x;
  endtask

  task automatic rd2(input logic [7:0] c, output logic [15:0] v);
    acc(1'b1, 1'b1, c);
    rd8(v[7:0]);
    rd8(v[15:8]);
  endtask

  task automatic wr2(input logic [7:0] c, input logic [15:0] v);
    acc(1'b1, 1'b1, c);
    acc(1'b0, 1'b1, v[7:0]);
    acc(1'b0, 1'b1, v[15:8]);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need.
  initial begin
    #100000;
    num_errors++;
    stop_test();
  end

  // Main sequence.
  initial begin
    logic [15:0] v;
    logic [7:0] b;
    int i;
    for (i = 0; i < 16; i++) ep_status[i] = 8'h90 + 8'(i);
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    rd2(`UEDC_CMD_CNT_RD, v);
    chk(v, `UEDC_CNT_RESET);
    rd2(`UEDC_CMD_CFG_RD, v);
    chk(v, `UEDC_CFG_RESET);
    $display("test reset_values done");
    for (i = 0; i < 16; i++) begin
      acc(1'b1, 1'b1, {`UEDC_NIB_STAT, i[3:0]});
      rd8(b);
      chk(16'(b), 16'h0090 + 16'(i));
    end
    acc(1'b0, 1'b1, 8'h00);
    acc(1'b1, 1'b1, 8'h5F);
    rd8(b);
    chk(16'(b), 16'h009F);
    acc(1'b1, 1'b1, `UEDC_CMD_BUFR_GAP);
    rd8(b);
    chk(16'(b), 16'h0000);
    $display("test status done");
    // Ten-byte packet framed with its length, written by the host into buffer 2.
    acc(1'b1, 1'b1, 8'h02);
    acc(1'b0, 1'b1, 8'h0A);
    acc(1'b0, 1'b1, 8'h00);
    for (i = 0; i < 10; i++) acc(1'b0, 1'b1, 8'hA1 + 8'(i));
    // A two-byte packet follows in the second half, for the double-buffer DMA read.
    for (i = 12; i < 36; i++) begin
      acc(1'b0, 1'b1, i == 32 ? 8'h02 : (i > 33 ? 8'h89 + 8'(i) : 8'h00));
    end
    acc(1'b1, 1'b1, 8'h12);
    rd8(b);
    chk(16'(b), 16'h000A);
    rd8(b);
    chk(16'(b), 16'h0000);
    rd8(b);
    chk(16'(b), 16'h00A1);
    acc(1'b1, 1'b1, 8'h12);
    rd8(b);
    chk(16'(b), 16'h000A);
    @(posedge core_clk) bus16 <= 1'b1;
    acc(1'b1, 1'b1, 8'h12);
    rd8(b);
    chk(host_rdata_r, 16'h000A);
    rd8(b);
    chk(host_rdata_r, 16'hA2A1);
    @(posedge core_clk) bus16 <= 1'b0;
    $display("test host_buffer done");
    // DMA read of that packet, the sink stalling until the FIFO refuses.
    wr2(`UEDC_CMD_CNT_WR, 16'h000C);
    ep_buf_full <= 16'h0004;
    wr2(`UEDC_CMD_CFG_WR, 16'h8028);
    rd2(`UEDC_CMD_CNT_RD, v);
    chk(v, 16'h000C);
    repeat (20) @(posedge core_clk);
    stall <= 1'b0;
    for (i = 0; i < 200 && dm.rxq.size() < 10; i++) @(posedge core_clk);
    // The engine now offers the packet in the second half of the double buffer.
    ep_buf_full <= 16'h0004;
    for (i = 0; i < 200 && dm.rxq.size() < 12; i++) @(posedge core_clk);
    repeat (20) @(posedge core_clk);
    chk(16'(dm.rxq.size()), 16'h000C);
    for (i = 0; i < 12; i++) begin
      chk(16'(dm.rxq[i]), {7'h00, 1'(i == 9 || i == 11), 8'hA1 + 8'(i)});
    end
    rd2(`UEDC_CMD_CNT_RD, v);
    chk(v, 16'h0000);
    rd2(`UEDC_CMD_CFG_RD, v);
    chk(v, 16'h8020);
    $display("test dma_read done");
    // DMA write of a short packet into IN buffer 3, cut off by external end of transfer.
    wr2(`UEDC_CMD_CNT_WR, 16'h0005);
    wr2(`UEDC_CMD_CFG_WR, 16'h0038);
    dm.txq.push_back(8'h5A);
    dm.txq.push_back(8'hC3);
    repeat (10) @(posedge core_clk);
    rd2(`UEDC_CMD_CNT_RD, v);
    chk(v, 16'h0003);
    @(posedge core_clk) end_of_transfer_signal <= 1'b1;
    for (i = 0; i < 50 && buf_commit_r !== 1'b1; i++) @(posedge core_clk);
    chk({11'h000, buf_commit_r, buf_ep_r}, 16'h0013);
    end_of_transfer_signal <= 1'b0;
    acc(1'b1, 1'b1, 8'h13);
    for (i = 0; i < 4; i++) begin
      rd8(b);
      chk(16'(b), 16'(exp_w[i]));
    end
    rd2(`UEDC_CMD_CFG_RD, v);
    chk(v, 16'h0030);
    $display("test dma_write done");
    // Bus reset stops DMA but keeps the programmed count.
    wr2(`UEDC_CMD_CNT_WR, 16'h0042);
    wr2(`UEDC_CMD_CFG_WR, 16'h0038);
    @(posedge core_clk);
    usb_bus_reset <= 1'b1;
    @(posedge core_clk);
    usb_bus_reset <= 1'b0;
    rd2(`UEDC_CMD_CFG_RD, v);
    chk(v, 16'h0030);
    wr2(`UEDC_CMD_CFG_WR, 16'h0008);
    rd2(`UEDC_CMD_CNT_RD, v);
    chk(v, 16'h0042);
    $display("test bus_reset done");
    // Reset command clears the count register and the configuration.
    acc(1'b1, 1'b1, `UEDC_CMD_RESET);
    rd2(`UEDC_CMD_CFG_RD, v);
    chk(v, `UEDC_CFG_RESET);
    wr2(`UEDC_CMD_CFG_WR, 16'h0008);
    rd2(`UEDC_CMD_CNT_RD, v);
    chk(v, `UEDC_CNT_RESET);
    $display("test reset_command done");
    stop_test();
  end
endmodule
